// *** verilog/dstt_defs.vh ***
// constants for the dual stage tick timer: byte offsets, field positions,
// divider tap base and reset values; included by the timer files
`ifndef DSTT_DEFS_VH
`define DSTT_DEFS_VH

`define DSTT_ADDR_W 8
`define DSTT_DATA_W 8

`define DSTT_OFS_TICK_CONTROL 8'h40
`define DSTT_OFS_FIRST_COUNT 8'h46
`define DSTT_OFS_SECOND_COUNT 8'h47
`define DSTT_OFS_IRQ_ENABLE_TWO 8'h01
`define DSTT_OFS_IRQ_FLAG_TWO 8'h03

`define DSTT_CTL_IP_LSB 0
`define DSTT_CTL_IP_MSB 2
`define DSTT_CTL_FRFQ_LSB 3
`define DSTT_CTL_FRFQ_MSB 4
`define DSTT_CTL_DIV_BIT 5
`define DSTT_CTL_HOLD_BIT 6
`define DSTT_CTL_SSEL_BIT 7

`define DSTT_IRQ_BIT 7

`define DSTT_CTL_RESET 8'h00
`define DSTT_COUNT_RESET 8'h00
`define DSTT_COUNT_MAX 8'hff

`define DSTT_FRAME_TAP_BASE 4

`endif

// *** verilog/dstt_counter8.v ***
// one 8-bit up counter stage with software load
// assumes inc_en is a one-cycle enable on ref_clk; a load wins over a count
`timescale 1ns/1ps
`include "dstt_defs.vh"

module dstt_counter8 (
    input wire ref_clk,
    input wire nrst,
    input wire inc_en,
    input wire load_en,
    input wire [7:0] load_data,
    output wire [7:0] count,
    output wire [7:0] count_inc,
    output wire carry
);

    reg [7:0] count_reg;
    reg [7:0] count_next;

    assign count = count_reg;
    assign count_inc = count_reg + 8'h01;
    // wrap from all ones, only when the stage really steps
    assign carry = inc_en && !load_en && (count_reg == `DSTT_COUNT_MAX);

    always @* begin
        count_next = count_reg;
        if (load_en) begin
            count_next = load_data;
        end else if (inc_en) begin
            count_next = count_inc;
        end
    end

    // no defined power-up value is promised to software; zero is chosen
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= `DSTT_COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

// *** verilog/dstt_timer.v ***
// dual stage tick timer: two chained 8-bit counters, frame clock and tick flag
// assumes aclk_pin and mclk_pin are slow compared to ref_clk (below 50 MHz),
// and a byte-wide register port driven by logic on ref_clk
//
// Overview of operation
// - two 8-bit counters or one 16-bit chain
// - interval code 0..7 gives /2,/2,/8../256
// - interval code picks one second counter bit
// - frame code picks aclk /32,/64,/128,/256
// - first counter divides aclk, feeds frame clock
// - first counter msb can clock second counter
// - software reads and writes first counter
// - software reads and writes second counter
// - ssel/div choose aclk, aclk/256, mclk source
// - cascade bit chains counters on aclk
// - 8-bit mode first counter always counts aclk
// - hold stops second; both bits stop first
// - register access works regardless of hold
// - pending flag clears when interrupt accepted
// - enable clears at reset; gated by global enable
`timescale 1ns/1ps
`include "dstt_defs.vh"

module dstt_timer (
    input wire ref_clk,
    input wire nrst,
    input wire aclk_pin,
    input wire mclk_pin,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    output wire reg_hit,
    input wire global_irq_enable,
    input wire irq_ack,
    output wire irq_req,
    output wire tick_irq_flag,
    output wire tick_irq_enable,
    output wire frame_clock,
    output wire second_stage_clock
);

    // clock source states of the second stage, one-hot
    localparam [3:0] SRC_ACLK = 4'b0001;
    localparam [3:0] SRC_DIV256 = 4'b0010;
    localparam [3:0] SRC_MCLK = 4'b0100;
    localparam [3:0] SRC_CHAIN = 4'b1000;

    // interval code to second counter bit index
    function [2:0] interval_tap;
        input [2:0] code;
        begin
            case (code)
                3'h0: interval_tap = 3'h0;
                3'h1: interval_tap = 3'h0;
                3'h2: interval_tap = 3'h2;
                3'h3: interval_tap = 3'h3;
                3'h4: interval_tap = 3'h4;
                3'h5: interval_tap = 3'h5;
                3'h6: interval_tap = 3'h6;
                3'h7: interval_tap = 3'h7;
                default: interval_tap = 3'h0;
            endcase
        end
    endfunction

    // address decode, shared by the write and read paths
    function is_addr;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            is_addr = (addr == ofs);
        end
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers; stage one feeds only stage two
    // ------------------------------------------------------------------
    reg [1:0] aclk_sync_reg;
    reg [1:0] mclk_sync_reg;
    reg aclk_last_reg;
    reg mclk_last_reg;
    wire aclk_tick;
    wire mclk_tick;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aclk_sync_reg <= 2'b00;
            mclk_sync_reg <= 2'b00;
            aclk_last_reg <= 1'b0;
            mclk_last_reg <= 1'b0;
        end else begin
            aclk_sync_reg <= {aclk_sync_reg[0], aclk_pin};
            mclk_sync_reg <= {mclk_sync_reg[0], mclk_pin};
            aclk_last_reg <= aclk_sync_reg[1];
            mclk_last_reg <= mclk_sync_reg[1];
        end
    end

    // rising edges of the slow clocks become one-cycle enables
    assign aclk_tick = aclk_sync_reg[1] && !aclk_last_reg;
    assign mclk_tick = mclk_sync_reg[1] && !mclk_last_reg;

    // ------------------------------------------------------------------
    // register write strobes
    // ------------------------------------------------------------------
    wire wr_ctl;
    wire wr_cnt1;
    wire wr_cnt2;
    wire wr_ie2;
    wire wr_irq_flag_reg_two;

    // no hold gating here: access is always possible
    assign wr_ctl = reg_wr && is_addr(reg_addr, `DSTT_OFS_TICK_CONTROL);
    assign wr_cnt1 = reg_wr && is_addr(reg_addr, `DSTT_OFS_FIRST_COUNT);
    assign wr_cnt2 = reg_wr && is_addr(reg_addr, `DSTT_OFS_SECOND_COUNT);
    assign wr_ie2 = reg_wr && is_addr(reg_addr, `DSTT_OFS_IRQ_ENABLE_TWO);
    assign wr_irq_flag_reg_two = reg_wr && is_addr(reg_addr, `DSTT_OFS_IRQ_FLAG_TWO);

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    reg [7:0] tick_control_reg;
    wire [2:0] interval_code;
    wire [1:0] frame_code;
    wire cascade_sel;
    wire hold_sel;
    wire ssel_sel;

    // software must program this after power-up; zero only for determinism
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tick_control_reg <= `DSTT_CTL_RESET;
        end else if (wr_ctl) begin
            tick_control_reg <= reg_wdata;
        end
    end

    assign interval_code = tick_control_reg[`DSTT_CTL_IP_MSB:`DSTT_CTL_IP_LSB];
    assign frame_code = tick_control_reg[`DSTT_CTL_FRFQ_MSB:`DSTT_CTL_FRFQ_LSB];
    assign cascade_sel = tick_control_reg[`DSTT_CTL_DIV_BIT];
    assign hold_sel = tick_control_reg[`DSTT_CTL_HOLD_BIT];
    assign ssel_sel = tick_control_reg[`DSTT_CTL_SSEL_BIT];

    // ------------------------------------------------------------------
    // first stage: divides aclk
    // ------------------------------------------------------------------
    wire first_inc;
    wire [7:0] first_count;
    wire first_carry;

    // stops only with hold and cascade together
    assign first_inc = aclk_tick && !(hold_sel && cascade_sel);

    dstt_counter8 u_first (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .inc_en(first_inc),
        .load_en(wr_cnt1),
        .load_data(reg_wdata),
        .count(first_count),
        .count_inc(),
        .carry(first_carry)
    );

    // ------------------------------------------------------------------
    // second stage clock source
    // ------------------------------------------------------------------
    reg [3:0] src_state;
    reg second_src_tick;

    always @* begin
        case ({ssel_sel, cascade_sel})
            2'b00: src_state = SRC_ACLK;
            2'b01: src_state = SRC_CHAIN;
            2'b10: src_state = SRC_MCLK;
            2'b11: src_state = SRC_DIV256;
            default: src_state = SRC_ACLK;
        endcase
    end

    // msb falling edge of the first stage is the aclk/256 step; using the
    // carry keeps it exact even after software reloads the first stage
    always @* begin
        case (src_state)
            SRC_ACLK: second_src_tick = aclk_tick;
            SRC_DIV256: second_src_tick = first_carry;
            SRC_MCLK: second_src_tick = mclk_tick;
            SRC_CHAIN: second_src_tick = first_carry;
            default: second_src_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // second stage
    // ------------------------------------------------------------------
    wire second_inc;
    wire [7:0] second_count;
    wire [7:0] second_count_inc;

    assign second_inc = second_src_tick && !hold_sel;

    dstt_counter8 u_second (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .inc_en(second_inc),
        .load_en(wr_cnt2),
        .load_data(reg_wdata),
        .count(second_count),
        .count_inc(second_count_inc),
        .carry()
    );

    // ------------------------------------------------------------------
    // tick event from the selected second stage bit
    // ------------------------------------------------------------------
    wire [2:0] tap_sel;
    wire tap_now;
    wire tap_after;
    wire tick_event;

    assign tap_sel = interval_tap(interval_code);
    assign tap_now = second_count[tap_sel];
    assign tap_after = second_count_inc[tap_sel];

    // only a counting step that raises the bit counts; software loads
    // never raise a tick, so one flag per full period of the bit
    assign tick_event = second_inc && !wr_cnt2 && !tap_now && tap_after;

    // ------------------------------------------------------------------
    // frame clock: one of four first stage bits
    // ------------------------------------------------------------------
    reg frame_clock_reg;
    wire [2:0] frame_tap;
    wire [31:0] frame_tap_sum;

    // tap index never exceeds 7, so the low three bits are the whole value
    assign frame_tap_sum = `DSTT_FRAME_TAP_BASE + {1'b0, frame_code};
    assign frame_tap = frame_tap_sum[2:0];

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            frame_clock_reg <= 1'b0;
        end else begin
            frame_clock_reg <= first_count[frame_tap];
        end
    end

    assign frame_clock = frame_clock_reg;

    // registered copy of the second stage step: the chosen source step gated by hold
    reg second_clk_reg;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            second_clk_reg <= 1'b0;
        end else begin
            second_clk_reg <= second_inc;
        end
    end

    assign second_stage_clock = second_clk_reg;

    // ------------------------------------------------------------------
    // interrupt flag and enable
    // ------------------------------------------------------------------
    reg flag_reg;
    reg flag_next;
    reg enable_reg;

    // hardware set beats an accept or a software clear in the same cycle
    always @* begin
        flag_next = flag_reg;
        if (irq_ack) begin
            flag_next = 1'b0;
        end
        if (wr_irq_flag_reg_two) begin
            flag_next = reg_wdata[`DSTT_IRQ_BIT];
        end
        if (tick_event) begin
            flag_next = 1'b1;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enable_reg <= 1'b0;
        end else if (wr_ie2) begin
            enable_reg <= reg_wdata[`DSTT_IRQ_BIT];
        end
    end

    assign tick_irq_flag = flag_reg;
    assign tick_irq_enable = enable_reg;
    assign irq_req = flag_reg && enable_reg && global_irq_enable;

    // ------------------------------------------------------------------
    // read path: byte wide, registered, unmapped reads give zero
    // ------------------------------------------------------------------
    reg [7:0] rdata_reg;
    reg [7:0] rdata_next;
    reg hit_reg;
    reg hit_next;

    // counters step on ref_clk enables, so a read always sees a whole value
    always @* begin
        rdata_next = 8'h00;
        hit_next = 1'b1;
        case (1'b1)
            is_addr(reg_addr, `DSTT_OFS_TICK_CONTROL): rdata_next = tick_control_reg;
            is_addr(reg_addr, `DSTT_OFS_FIRST_COUNT): rdata_next = first_count;
            is_addr(reg_addr, `DSTT_OFS_SECOND_COUNT): rdata_next = second_count;
            is_addr(reg_addr, `DSTT_OFS_IRQ_ENABLE_TWO): rdata_next = {enable_reg, 7'h00};
            is_addr(reg_addr, `DSTT_OFS_IRQ_FLAG_TWO): rdata_next = {flag_reg, 7'h00};
            default: hit_next = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
            hit_reg <= 1'b0;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
            hit_reg <= hit_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_hit = hit_reg;

endmodule

// *** testbench/dstt_timer_sva.sv ***
// assertions on the dual stage tick timer ports
// bound into dstt_timer; sees only its ports, one clock domain
`timescale 1ns/1ps
module dstt_timer_sva (
    input wire ref_clk,
    input wire nrst,
    input wire aclk_pin,
    input wire mclk_pin,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_hit,
    input wire global_irq_enable,
    input wire irq_ack,
    input wire irq_req,
    input wire tick_irq_flag,
    input wire tick_irq_enable,
    input wire frame_clock,
    input wire second_stage_clock
);
    wire mapped;
    assign mapped = reg_addr == 8'h40 || reg_addr == 8'h46 || reg_addr == 8'h47 ||
                    reg_addr == 8'h01 || reg_addr == 8'h03;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_irq_gate: assert property (irq_req == (tick_irq_flag && tick_irq_enable && global_irq_enable))
        else $error("irq request not gated by flag and enables");
    // a step landing in the same cycle as the ack may set the flag again
    a_ack_clears: assert property (irq_ack && !reg_wr |=> !tick_irq_flag || second_stage_clock)
        else $error("flag survived an accept");
    a_enable_reset: assert property (disable iff (1'b0) !nrst |-> !tick_irq_enable && !tick_irq_flag)
        else $error("enable or flag set during reset");
    a_rd_unmapped: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read not refused");
    a_rd_mapped: assert property (reg_rd && mapped |=> reg_hit)
        else $error("mapped read not acknowledged");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_ctl_readback: assert property (reg_wr && reg_addr == 8'h40 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h40
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("control byte not read back");
    a_step_pulse: assert property (second_stage_clock |=> !second_stage_clock [*2])
        else $error("second stage pulse too long");
endmodule
bind dstt_timer dstt_timer_sva dstt_timer_sva_inst (.ref_clk(ref_clk), .nrst(nrst), .aclk_pin(aclk_pin),
    .mclk_pin(mclk_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
    .irq_req(irq_req), .tick_irq_flag(tick_irq_flag), .tick_irq_enable(tick_irq_enable),
    .frame_clock(frame_clock), .second_stage_clock(second_stage_clock));

// *** testbench/dstt_timer_tb.sv ***
// self-checking bench for the dual stage tick timer
// drives pins and the byte register port itself at ref_clk edges
`timescale 1ns/1ps
module dstt_timer_tb;
    reg ref_clk = 1'b0;
    reg nrst;
    reg aclk_pin = 1'b0;
    reg mclk_pin = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg global_irq_enable = 1'b0;
    reg irq_ack = 1'b0;
    wire [7:0] reg_rdata;
    wire reg_hit, irq_req, tick_irq_flag, tick_irq_enable, frame_clock, second_stage_clock;
    integer n_fail = 0;
    integer n_tests = 0;
    integer n_steps = 0;
    integer i;
    integer t;
    reg [1:0] f;
    reg [7:0] rv;
    always #2.5 ref_clk = ~ref_clk;
    // counts second stage step pulses as the design shows them
    always @(posedge ref_clk) begin
        if (second_stage_clock === 1'b1) begin
            n_steps <= n_steps + 1;
        end
    end
    dstt_timer dstt_timer_inst (.ref_clk(ref_clk), .nrst(nrst), .aclk_pin(aclk_pin), .mclk_pin(mclk_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq_req(irq_req),
        .tick_irq_flag(tick_irq_flag), .tick_irq_enable(tick_irq_enable), .frame_clock(frame_clock),
        .second_stage_clock(second_stage_clock));
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    task chk8(input [7:0] exp, input [7:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk1(input exp, input got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            @(posedge ref_clk);
            #1;
            chk8(exp, reg_rdata);
        end
    endtask
    // pin edges well below ref_clk/4 so the synchronisers see each one
    task pulses(input sel, input integer n);
        begin
            repeat (n) begin
                @(posedge ref_clk);
                if (sel) mclk_pin <= 1'b1; else aclk_pin <= 1'b1;
                repeat (4) @(posedge ref_clk);
                if (sel) mclk_pin <= 1'b0; else aclk_pin <= 1'b0;
                repeat (3) @(posedge ref_clk);
            end
            repeat (6) @(posedge ref_clk);
            #1;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        complete_run;
    end
    initial begin
        nrst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        rdc(8'h01, 8'h00);
        wr(8'h40, 8'h7b);
        rdc(8'h40, 8'h7b);
        wr(8'h46, 8'h12);
        rdc(8'h46, 8'h12);
        wr(8'h47, 8'ha5);
        rdc(8'h47, 8'ha5);
        rdc(8'h50, 8'h00);
        chk1(1'b0, reg_hit);
        $display("test 1 done");
        wr(8'h40, 8'h00);
        wr(8'h46, 8'h00);
        wr(8'h47, 8'h00);
        pulses(1'b0, 3);
        rdc(8'h46, 8'h03);
        rdc(8'h47, 8'h03);
        wr(8'h40, 8'h40);
        pulses(1'b0, 2);
        rdc(8'h46, 8'h05);
        rdc(8'h47, 8'h03);
        wr(8'h40, 8'h60);
        pulses(1'b0, 2);
        rdc(8'h46, 8'h05);
        $display("test 2 done");
        wr(8'h46, 8'hfe);
        wr(8'h47, 8'h07);
        wr(8'h40, 8'h20);
        pulses(1'b0, 3);
        rdc(8'h46, 8'h01);
        rdc(8'h47, 8'h08);
        wr(8'h40, 8'ha0);
        wr(8'h46, 8'hff);
        pulses(1'b0, 1);
        rdc(8'h47, 8'h09);
        wr(8'h40, 8'h80);
        t = n_steps;
        pulses(1'b1, 2);
        chk8(8'h02, n_steps[7:0] - t[7:0]);
        rdc(8'h47, 8'h0b);
        rdc(8'h46, 8'h00);
        $display("test 3 done");
        wr(8'h03, 8'h00);
        wr(8'h01, 8'h80);
        global_irq_enable <= 1'b1;
        #1;
        chk1(1'b1, tick_irq_enable);
        for (i = 0; i < 8; i = i + 1) begin
            t = (i < 2) ? 0 : i;
            wr(8'h40, i[7:0]);
            wr(8'h47, 8'hff >> (7 - t));
            pulses(1'b0, 1);
            chk1(1'b0, tick_irq_flag);
            wr(8'h47, 8'hff >> (8 - t));
            pulses(1'b0, 1);
            chk1(1'b1, tick_irq_flag);
            chk1(1'b1, irq_req);
            rdc(8'h03, 8'h80);
            @(posedge ref_clk);
            irq_ack <= 1'b1;
            @(posedge ref_clk);
            irq_ack <= 1'b0;
            @(posedge ref_clk);
            #1;
            chk1(1'b0, tick_irq_flag);
        end
        global_irq_enable <= 1'b0;
        wr(8'h03, 8'h80);
        #1;
        chk1(1'b0, irq_req);
        chk1(1'b1, tick_irq_flag);
        wr(8'h03, 8'h00);
        rdc(8'h03, 8'h00);
        $display("test 4 done");
        for (i = 0; i < 4; i = i + 1) begin
            f = i[1:0];
            wr(8'h40, {3'b011, f, 3'b000});
            wr(8'h46, 8'h10 << i);
            repeat (3) @(posedge ref_clk);
            #1;
            chk1(1'b1, frame_clock);
            wr(8'h46, ~(8'h10 << i));
            repeat (3) @(posedge ref_clk);
            #1;
            chk1(1'b0, frame_clock);
        end
        $display("test 5 done");
        complete_run;
    end
endmodule
